// File: usb_fast_charge_negotiator.sv
// Purpose: Fast-charge negotiation, feedback current and power limiting
// Assumes: Comparator outputs and straps are asynchronous pins;
//   current and voltage measurements come from logic on clk
// Notes: Feedback code is signed uA, positive sinks current
// Overview of operation
// - DP high must persist the DP-high filter time before acceptance.
// - DM low must persist about 2 ms to count as handshake.
// - Voltage codes stable 40 ms before use; step pulses filtered.
// - Feedback current is set in 1 uA steps, source or sink.
// - A granted 9 V output sinks 40 uA of feedback current.
// - At default 5 V the feedback current is zero unless the power limit backs it off.
// - Identify the standard, grant or refuse; refusals leave feedback unchanged.
// - For ordinary devices drive DP and DM to finish detection.
// - Below 6 V, hold output current at 3 A.
// - Above 6 V, hold current times voltage at 18 W.
// - Strap floating caps grants at 9 V; grounded allows 12 V.
// - Indicator on in fast-charge mode, off once it ends.
// - Probe pin 1 at start-up: sense mode or thermistor mode.
// - Thermistor fault above 1.5 V or between 0.1 and 0.5 V.
// - Thermistor mode disables the current-sensing protocol.
// - Default state shorts DP to DM as a charging port.
`timescale 1ns/1ps
`default_nettype none

module glitch_filter #(
	parameter int COUNT = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic level,
	output logic qual_q,
	output logic hit_q
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= '0;
			qual_q <= 1'b0;
			hit_q <= 1'b0;
		end
		else if (!level)
		begin
			cnt_q <= '0;
			qual_q <= 1'b0;
			hit_q <= 1'b0;
		end
		else if (cnt_q == W'(COUNT - 1))
		begin
			qual_q <= 1'b1;
			hit_q <= !qual_q;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			hit_q <= 1'b0;
		end
	end
endmodule : glitch_filter

module usb_fast_charge_negotiator
	import fcn_pkg::*;
#(
	parameter int P_DP_HIGH_CYC = fcn_pkg::DP_HIGH_CYC,
	parameter int P_DM_LOW_CYC = fcn_pkg::DM_LOW_CYC,
	parameter int P_VCHG_CYC = fcn_pkg::VCHG_CYC,
	parameter int P_CONT_CYC = fcn_pkg::CONT_CYC,
	parameter int P_PROBE_CYC = fcn_pkg::PROBE_CYC,
	parameter int P_LIMIT_TICK_CYC = fcn_pkg::LIMIT_TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Line comparators
	input wire logic dp_data_cmp,
	input wire logic dm_data_cmp,
	input wire logic dp_sel_cmp,
	input wire logic dm_sel_cmp,
	// Multiplexed pin comparators and strap
	input wire logic probe_low_cmp,
	input wire logic ntc_above_sc,
	input wire logic ntc_above_vh,
	input wire logic ntc_above_vl,
	input wire logic sel_strap_low,
	// Measurements
	input wire logic [12:0] meas_current_ma,
	input wire logic [13:0] meas_voltage_mv,
	// Line and pin drives
	output logic dcp_short_en,
	output logic div_level_en,
	output logic dm_pulldown_en,
	output logic probe_src_en,
	output logic sense_mode,
	output logic signed [7:0] feedback_current_output,
	output logic fast_charge_indicator,
	output logic temp_fault_flag,
	output logic irq,
	// Avalon-MM slave
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import fcn_pkg::*;

	localparam int NPIN = 9;
	localparam int VW = $clog2(P_VCHG_CYC + 1);
	localparam int LW = $clog2(P_LIMIT_TICK_CYC + 1);

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;
	logic [NPIN-1:0] pin_q;
	logic dp_data;
	logic dm_data;
	logic dp_sel;
	logic dm_sel;
	logic probe_low;
	logic strap_low;
	neg_state_t state_q;
	logic cont_q;
	logic strap_12v_q;
	logic signed [7:0] step_q;
	logic [7:0] backoff_q;
	logic limiting_q;
	logic [2:0] ctrl_q;
	logic [EV_W-1:0] ev_q;
	logic [EV_W-1:0] irq_status_q;
	logic [EV_W-1:0] irq_enable_q;
	logic [2:0] code_q;
	logic [VW-1:0] code_cnt_q;
	logic code_apply_q;
	logic [LW-1:0] tick_cnt_q;
	logic tick_q;
	logic dp_high_hit;
	logic dm_low_hit;
	logic detach_hit;
	logic up_hit;
	logic down_hit;
	logic probe_hit;
	logic bus_go;
	logic over_limit;
	logic temp_bad;
	logic signed [7:0] cap_step;
	logic signed [7:0] req_step;
	logic req_fixed;
	logic req_cont;
	logic signed [9:0] fb_raw;
	logic [26:0] power_uw;

	// Three-stage pin synchroniser; change taken once stages 2 and 3 agree
	assign pin_raw = {sel_strap_low, ntc_above_vl, ntc_above_vh,
		ntc_above_sc, probe_low_cmp, dm_sel_cmp, dp_sel_cmp,
		dm_data_cmp, dp_data_cmp};

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end
		else
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < NPIN; i++)
			begin
				if (s2_q[i] == s3_q[i])
					pin_q[i] <= s3_q[i];
			end
		end
	end

	assign dp_data = pin_q[0];
	assign dm_data = pin_q[1];
	assign dp_sel = pin_q[2];
	assign dm_sel = pin_q[3];
	assign probe_low = pin_q[4];
	assign strap_low = pin_q[8];

	glitch_filter #(.COUNT(P_DP_HIGH_CYC)) u_dp_high (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(dp_data && state_q == ST_DCP && ctrl_q[CTRL_FC_EN_BIT]),
		.qual_q(),
		.hit_q(dp_high_hit)
	);

	glitch_filter #(.COUNT(P_DM_LOW_CYC)) u_dm_low (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(!dm_data && state_q == ST_WAIT_DM),
		.qual_q(),
		.hit_q(dm_low_hit)
	);

	glitch_filter #(.COUNT(P_DM_LOW_CYC)) u_detach (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(!dp_data && (state_q == ST_FAST || state_q == ST_WAIT_DM)),
		.qual_q(),
		.hit_q(detach_hit)
	);

	glitch_filter #(.COUNT(P_CONT_CYC)) u_up (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(cont_q && dp_sel),
		.qual_q(),
		.hit_q(up_hit)
	);

	glitch_filter #(.COUNT(P_CONT_CYC)) u_down (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(cont_q && !dm_sel),
		.qual_q(),
		.hit_q(down_hit)
	);

	glitch_filter #(.COUNT(P_PROBE_CYC)) u_probe (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(state_q == ST_PROBE),
		.qual_q(),
		.hit_q(probe_hit)
	);

	// code must stay unchanged for the full window
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			code_q <= '0;
			code_cnt_q <= '0;
			code_apply_q <= 1'b0;
		end
		else
		begin
			code_q <= {dp_sel, dm_sel, dm_data};
			code_apply_q <= 1'b0;
			if (state_q != ST_FAST || code_q != {dp_sel, dm_sel, dm_data})
				code_cnt_q <= '0;
			else if (code_cnt_q == VW'(P_VCHG_CYC - 1))
			begin
				code_cnt_q <= code_cnt_q + 1'b1;
				code_apply_q <= 1'b1;
			end
			else if (code_cnt_q != VW'(P_VCHG_CYC))
				code_cnt_q <= code_cnt_q + 1'b1;
		end
	end

	// decode of the stable line code
	always_comb
	begin
		req_step = STEP_DEFAULT;
		req_fixed = 1'b0;
		req_cont = 1'b0;
		unique case (code_q)
			3'b000:
			begin
				req_fixed = 1'b1;
			end
			3'b101:
			begin
				req_fixed = 1'b1;
				req_step = STEP_9V;
			end
			3'b001:
			begin
				req_fixed = 1'b1;
				req_step = STEP_12V;
			end
			3'b011:
				req_cont = 1'b1;
			default:
				req_fixed = 1'b0;
		endcase
	end

	assign cap_step = strap_12v_q ? STEP_12V : STEP_9V;

	// Negotiation sequence
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_PROBE;
			step_q <= STEP_DEFAULT;
			cont_q <= 1'b0;
			sense_mode <= 1'b0;
			strap_12v_q <= 1'b0;
			ev_q <= '0;
		end
		else
		begin
			ev_q <= '0;
			ev_q[EV_TEMP_FAULT] <= temp_bad && !temp_fault_flag;
			ev_q[EV_LIMIT] <= over_limit && !limiting_q;
			unique case (state_q)
				ST_PROBE:
				begin
					if (probe_hit)
					begin
						sense_mode <= probe_low;
						strap_12v_q <= strap_low;
						state_q <= ST_DCP;
					end
				end
				ST_DCP:
				begin
					if (dp_high_hit)
						state_q <= ST_WAIT_DM;
				end
				ST_WAIT_DM:
				begin
					if (detach_hit)
					begin
						state_q <= ST_DCP;
						ev_q[EV_DETACH] <= 1'b1;
					end
					else if (dm_low_hit)
					begin
						state_q <= ST_FAST;
						ev_q[EV_HANDSHAKE] <= 1'b1;
					end
				end
				ST_FAST:
				begin
					if (detach_hit || !ctrl_q[CTRL_FC_EN_BIT])
					begin
						state_q <= ST_DCP;
						step_q <= STEP_DEFAULT;
						cont_q <= 1'b0;
						ev_q[EV_DETACH] <= 1'b1;
					end
					else if (code_apply_q)
					begin
						if (req_cont && sense_mode)
						begin
							cont_q <= 1'b1;
							ev_q[EV_GRANT] <= 1'b1;
						end
						else if (req_fixed && req_step <= cap_step)
						begin
							cont_q <= 1'b0;
							step_q <= req_step;
							ev_q[EV_GRANT] <= 1'b1;
						end
						else
							ev_q[EV_REFUSE] <= 1'b1;
					end
					else if (up_hit)
					begin
						if (step_q < cap_step)
						begin
							step_q <= step_q + 8'sh01;
							ev_q[EV_GRANT] <= 1'b1;
						end
						else
							ev_q[EV_REFUSE] <= 1'b1;
					end
					else if (down_hit)
					begin
						if (step_q > STEP_MIN)
						begin
							step_q <= step_q - 8'sh01;
							ev_q[EV_GRANT] <= 1'b1;
						end
						else
							ev_q[EV_REFUSE] <= 1'b1;
					end
				end
			endcase
		end
	end

	assign power_uw = {14'h0000, meas_current_ma} * {13'h0000, meas_voltage_mv};
	assign over_limit = sense_mode && ctrl_q[CTRL_LIMIT_BIT]
		&& ((meas_voltage_mv < V_KNEE_MV && meas_current_ma > I_LIMIT_MA)
		|| (meas_voltage_mv >= V_KNEE_MV && power_uw > P_LIMIT_UW));

	// Slow tick keeps the loop from fighting the regulator
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == LW'(P_LIMIT_TICK_CYC - 1))
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// back off 1 uA per tick while over
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			backoff_q <= '0;
			limiting_q <= 1'b0;
		end
		else
		begin
			limiting_q <= over_limit;
			if (state_q != ST_FAST)
				backoff_q <= '0;
			else if (tick_q && over_limit && backoff_q != BACKOFF_MAX)
				backoff_q <= backoff_q + 8'h01;
			else if (tick_q && !over_limit && backoff_q != 8'h00)
				backoff_q <= backoff_q - 8'h01;
		end
	end

	// 1 uA resolution, sign selects source or sink
	// step 20 gives 40 uA sink
	assign fb_raw = {step_q[7], step_q, 1'b0} - {2'b00, backoff_q};

	// zero at default unless a limit acts
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			feedback_current_output <= 8'sh00;
		else if (state_q != ST_FAST)
			feedback_current_output <= 8'sh00;
		else if (fb_raw < FB_MIN)
			feedback_current_output <= FB_MIN[7:0];
		else
			feedback_current_output <= fb_raw[7:0];
	end

	// window test on the thermistor comparators
	assign temp_bad = !sense_mode && state_q != ST_PROBE
		&& (pin_q[7] || (pin_q[5] && !pin_q[6]));

	// Line drives and indicator
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dcp_short_en <= 1'b1;
			div_level_en <= 1'b0;
			dm_pulldown_en <= 1'b0;
			probe_src_en <= 1'b1;
			fast_charge_indicator <= 1'b0;
			temp_fault_flag <= 1'b0;
		end
		else
		begin
			dcp_short_en <= (state_q == ST_PROBE || state_q == ST_DCP)
				&& !ctrl_q[CTRL_DIV_BIT];
			div_level_en <= state_q == ST_DCP && ctrl_q[CTRL_DIV_BIT];
			dm_pulldown_en <= state_q == ST_WAIT_DM || state_q == ST_FAST;
			probe_src_en <= state_q == ST_PROBE;
			fast_charge_indicator <= state_q == ST_FAST;
			temp_fault_flag <= temp_bad;
		end
	end

	// Avalon slave: one wait cycle, then the access completes
	assign bus_go = (avs_read || avs_write) && avs_waitrequest;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end
		else if (bus_go)
		begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= '0;
			if (avs_read)
			begin
				unique case (avs_address)
					REG_CTRL:
						avs_readdata <= {29'h0, ctrl_q};
					REG_STATUS:
						avs_readdata <= {8'h00, step_q, feedback_current_output,
							1'b0, limiting_q, cont_q, temp_fault_flag,
							strap_12v_q, sense_mode, state_q};
					REG_IRQ_STATUS:
						avs_readdata <= {26'h0, irq_status_q};
					REG_IRQ_ENABLE:
						avs_readdata <= {26'h0, irq_enable_q};
					default:
						avs_readdata <= '0;
				endcase
			end
		end
		else
			avs_waitrequest <= 1'b1;
	end

	// Writes land on the edge that completes the access
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_q <= CTRL_RESET;
			irq_enable_q <= '0;
		end
		else if (avs_write && !avs_waitrequest)
		begin
			if (avs_address == REG_CTRL)
				ctrl_q <= avs_writedata[2:0];
			if (avs_address == REG_IRQ_ENABLE)
				irq_enable_q <= avs_writedata[EV_W-1:0];
		end
	end

	// Sticky events; a new event beats a simultaneous clear
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_status_q <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (avs_write && !avs_waitrequest && avs_address == REG_IRQ_CLEAR)
				irq_status_q <= (irq_status_q & ~avs_writedata[EV_W-1:0])
					| ev_q;
			else
				irq_status_q <= irq_status_q | ev_q;
			irq <= |(irq_status_q & irq_enable_q);
		end
	end
endmodule : usb_fast_charge_negotiator

`default_nettype wire

// File: fcn_pkg.sv
// Purpose: Shared constants for the fast-charge negotiator
// Assumes: 40 MHz clock; comparator levels arrive as digital pins
// Notes: Times in us, cycle counts derived from the clock rate
`default_nettype none
package fcn_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;

	// Filter times (least times, exact multiples of the clock)
	localparam int DP_HIGH_FILTER_US = 1_250_000;
	localparam int DM_LOW_FILTER_US = 2_000;
	localparam int VCHG_FILTER_US = 40_000;
	localparam int CONT_FILTER_US = 100;
	localparam int PROBE_SETTLE_US = 1_000;
	localparam int LIMIT_TICK_US = 100;
	localparam int DP_HIGH_CYC = DP_HIGH_FILTER_US * CYC_PER_US;
	localparam int DM_LOW_CYC = DM_LOW_FILTER_US * CYC_PER_US;
	localparam int VCHG_CYC = VCHG_FILTER_US * CYC_PER_US;
	localparam int CONT_CYC = CONT_FILTER_US * CYC_PER_US;
	localparam int PROBE_CYC = PROBE_SETTLE_US * CYC_PER_US;
	localparam int LIMIT_TICK_CYC = LIMIT_TICK_US * CYC_PER_US;

	// Register indices (byte address = 4 * index)
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_IRQ_STATUS = 3'h2;
	localparam logic [2:0] REG_IRQ_CLEAR = 3'h3;
	localparam logic [2:0] REG_IRQ_ENABLE = 3'h4;
	localparam int CTRL_FC_EN_BIT = 0;
	localparam int CTRL_DIV_BIT = 1;
	localparam int CTRL_LIMIT_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h5;

	// Event bits
	localparam int EV_HANDSHAKE = 0;
	localparam int EV_GRANT = 1;
	localparam int EV_REFUSE = 2;
	localparam int EV_DETACH = 3;
	localparam int EV_TEMP_FAULT = 4;
	localparam int EV_LIMIT = 5;
	localparam int EV_W = 6;

	// Voltage in 200 mV steps from 5 V; 2 uA of sink per step
	localparam logic signed [7:0] STEP_DEFAULT = 8'sh00;
	localparam logic signed [7:0] STEP_MIN = -8'sh07;
	localparam logic signed [7:0] STEP_9V = 8'sh14;
	localparam logic signed [7:0] STEP_12V = 8'sh23;
	localparam logic signed [9:0] FB_MIN = -10'sh00e;
	localparam logic [7:0] BACKOFF_MAX = 8'h54;

	// Power limits
	localparam logic [12:0] I_LIMIT_MA = 13'hbb8;
	localparam logic [13:0] V_KNEE_MV = 14'h1770;
	localparam logic [26:0] P_LIMIT_UW = 27'h112_a880;

	typedef enum logic [1:0] {
		ST_PROBE = 2'b00,
		ST_DCP = 2'b01,
		ST_WAIT_DM = 2'b11,
		ST_FAST = 2'b10
	} neg_state_t;
endpackage : fcn_pkg
`default_nettype wire

// File: fcn_monitor.sv
// Purpose: Port checks for the fast-charge negotiator
// Assumes: One clock, sys_rst async active high
// Notes: Run counters watch the raw pins; sync only lengthens runs
`timescale 1ns/1ps
`default_nettype none
module fcn_monitor
	import fcn_pkg::*;
#(
	parameter int P_DP_HIGH_CYC = 200,
	parameter int P_DM_LOW_CYC = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Line comparators
	input wire logic dp_data_cmp,
	input wire logic dm_data_cmp,
	// Bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Drives
	input wire logic dcp_short_en,
	input wire logic dm_pulldown_en,
	input wire logic probe_src_en,
	input wire logic sense_mode,
	input wire logic signed [7:0] feedback_current_output,
	input wire logic fast_charge_indicator,
	input wire logic temp_fault_flag
);
	int dp_high_q;
	int dm_low_q;

	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dp_high_q <= 0;
			dm_low_q <= 0;
		end
		else
		begin
			dp_high_q <= dp_data_cmp ? dp_high_q + 1 : 0;
			dm_low_q <= dm_data_cmp ? 0 : dm_low_q + 1;
		end
	end

	sequence req_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence home_state;
		feedback_current_output == 8'sh00 && !fast_charge_indicator;
	endsequence

	bus_answer_a: assert property (req_taken |=> !avs_waitrequest)
		else $error("bus answer late");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	dp_filter_a: assert property (
		$fell(dcp_short_en) && dm_pulldown_en |-> dp_high_q >= P_DP_HIGH_CYC)
		else $error("dp high accepted early");
	dm_filter_a: assert property (
		$rose(fast_charge_indicator) |-> dm_low_q >= P_DM_LOW_CYC
		&& dm_pulldown_en && !dcp_short_en)
		else $error("fast mode entered early");
	detach_home_a: assert property (
		$rose(dcp_short_en) |-> ##[0:2] home_state)
		else $error("detach left feedback or indicator");
	fb_range_a: assert property (
		feedback_current_output >= FB_MIN
		&& feedback_current_output <= 8'sh46)
		else $error("feedback out of range");
	therm_fb_a: assert property (
		!sense_mode && !probe_src_en |-> feedback_current_output >= 8'sh00)
		else $error("sourcing in thermistor mode");
	sense_fault_a: assert property (sense_mode |-> !temp_fault_flag)
		else $error("fault flag in sense mode");
	probe_hold_a: assert property ($fell(sys_rst) |-> probe_src_en [*8])
		else $error("probe source cut short");
endmodule : fcn_monitor

bind usb_fast_charge_negotiator fcn_monitor #(
	.P_DP_HIGH_CYC(P_DP_HIGH_CYC),
	.P_DM_LOW_CYC(P_DM_LOW_CYC)
) fcn_monitor_inst (
	.clk(clk), .sys_rst(sys_rst),
	.dp_data_cmp(dp_data_cmp), .dm_data_cmp(dm_data_cmp),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.dcp_short_en(dcp_short_en), .dm_pulldown_en(dm_pulldown_en),
	.probe_src_en(probe_src_en), .sense_mode(sense_mode),
	.feedback_current_output(feedback_current_output),
	.fast_charge_indicator(fast_charge_indicator),
	.temp_fault_flag(temp_fault_flag)
);
`default_nettype wire

// File: fcn_device_model.sv
// Purpose: Attached portable device and regulator loop
// Assumes: Bench picks phase 0 detached, 1 handshake, 2 request
// Notes: Regulator moves 100 mV per uA of feedback sink
`timescale 1ns/1ps
`default_nettype none
module fcn_device_model (
	// Bench control
	input wire logic [1:0] phase,
	input wire logic [2:0] req_code,
	// Negotiator drives
	input wire logic dcp_short_en,
	input wire logic signed [7:0] feedback_current_output,
	// Line comparators and regulator output
	output logic dp_data_cmp,
	output logic dm_data_cmp,
	output logic dp_sel_cmp,
	output logic dm_sel_cmp,
	output logic [13:0] meas_voltage_mv
);
	always_comb
	begin
		dp_data_cmp = phase != 2'h0;
		dm_data_cmp = dcp_short_en & dp_data_cmp;
		dp_sel_cmp = 1'b0;
		dm_sel_cmp = 1'b0;
		if (phase == 2'h2)
		begin
			dp_sel_cmp = req_code[2];
			dm_sel_cmp = req_code[1];
			dm_data_cmp = req_code[0];
		end
	end
	// 9 V at 40 uA sink
	assign meas_voltage_mv = 14'(5000 + 100 * int'(feedback_current_output));
endmodule : fcn_device_model
`default_nettype wire

// File: tb_usb_fast_charge_negotiator.sv
// Purpose: Self-checking bench for the fast-charge negotiator
// Assumes: Filter counts shortened by parameters, 40 MHz clock
// Notes: Waits are the shortened filter counts plus sync margin
`timescale 1ns/1ps
`default_nettype none
module tb_usb_fast_charge_negotiator;
	import fcn_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic probe_low_cmp = 1'b1;
	logic ntc_above_sc = 1'b0;
	logic ntc_above_vh = 1'b0;
	logic ntc_above_vl = 1'b0;
	logic sel_strap_low = 1'b0;
	logic [12:0] meas_current_ma = 13'h3e8;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [1:0] phase = 2'h0;
	logic [2:0] req_code = 3'h0;
	logic [3:0] ntc_tab [3] = '{4'h3, 4'hf, 4'h6};
	logic dp_data_cmp, dm_data_cmp, dp_sel_cmp, dm_sel_cmp;
	logic [13:0] meas_voltage_mv;
	logic dcp_short_en, div_level_en, dm_pulldown_en, probe_src_en;
	logic sense_mode, fast_charge_indicator, temp_fault_flag, irq;
	logic signed [7:0] feedback_current_output;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int miscompares = 0;
	int comparisons = 0;

	always #12.5 clk = ~clk;

	usb_fast_charge_negotiator #(.P_DP_HIGH_CYC(200), .P_DM_LOW_CYC(20),
		.P_VCHG_CYC(50), .P_CONT_CYC(8), .P_PROBE_CYC(10),
		.P_LIMIT_TICK_CYC(4)) usb_fast_charge_negotiator_inst (
		.clk(clk), .sys_rst(sys_rst), .dp_data_cmp(dp_data_cmp),
		.dm_data_cmp(dm_data_cmp), .dp_sel_cmp(dp_sel_cmp),
		.dm_sel_cmp(dm_sel_cmp), .probe_low_cmp(probe_low_cmp),
		.ntc_above_sc(ntc_above_sc), .ntc_above_vh(ntc_above_vh),
		.ntc_above_vl(ntc_above_vl), .sel_strap_low(sel_strap_low),
		.meas_current_ma(meas_current_ma), .meas_voltage_mv(meas_voltage_mv),
		.dcp_short_en(dcp_short_en), .div_level_en(div_level_en),
		.dm_pulldown_en(dm_pulldown_en), .probe_src_en(probe_src_en),
		.sense_mode(sense_mode),
		.feedback_current_output(feedback_current_output),
		.fast_charge_indicator(fast_charge_indicator),
		.temp_fault_flag(temp_fault_flag), .irq(irq),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	fcn_device_model fcn_device_model_inst (.phase(phase),
		.req_code(req_code), .dcp_short_en(dcp_short_en),
		.feedback_current_output(feedback_current_output),
		.dp_data_cmp(dp_data_cmp), .dm_data_cmp(dm_data_cmp),
		.dp_sel_cmp(dp_sel_cmp), .dm_sel_cmp(dm_sel_cmp),
		.meas_voltage_mv(meas_voltage_mv));

	task automatic stop_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [2:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		do
		begin
			@(posedge clk);
			n++;
			if (n > 40)
			begin
				miscompares++;
				stop_test();
			end
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
		wait_cyc(2);
	endtask : wr

	task automatic rchk(input logic [2:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d & m, e);
	endtask : rchk

	task automatic attach();
		phase <= 2'h1;
		wait_cyc(212);
		rchk(REG_STATUS, 32'h3, 32'h3);
		chk(32'(dcp_short_en), 32'h0);
		wait_cyc(30);
		chk(32'(fast_charge_indicator), 32'h1);
	endtask : attach

	task automatic set_req(input logic [2:0] c, input logic signed [7:0] e);
		req_code <= c;
		wait_cyc(70);
		chk(32'(feedback_current_output), 32'(e));
	endtask : set_req

	initial
	begin
		wait_cyc(20);
		sys_rst <= 1'b0;
		wait_cyc(30);
		rchk(REG_CTRL, 32'hffffffff, 32'h5);
		rchk(REG_IRQ_ENABLE, 32'hffffffff, 32'h0);
		rchk(REG_IRQ_CLEAR, 32'hffffffff, 32'h0);
		rchk(3'h6, 32'hffffffff, 32'h0);
		wr(REG_STATUS, 32'hffffffff);
		rchk(REG_STATUS, 32'hf, 32'h5);
		chk(32'(feedback_current_output), 32'h0);
		chk(32'(dcp_short_en), 32'h1);
		chk(32'(probe_src_en), 32'h0);
		wr(REG_CTRL, 32'h7);
		chk(32'(div_level_en), 32'h1);
		chk(32'(dcp_short_en), 32'h0);
		wr(REG_CTRL, 32'h5);
		chk(32'(div_level_en), 32'h0);
		chk(32'(dcp_short_en), 32'h1);
		$display("test registers done");
		phase <= 2'h1;
		wait_cyc(190);
		phase <= 2'h0;
		wait_cyc(10);
		rchk(REG_STATUS, 32'h3, 32'h1);
		attach();
		wr(REG_IRQ_ENABLE, 32'h3f);
		chk(32'(irq), 32'h1);
		rchk(REG_IRQ_STATUS, 32'h1, 32'h1);
		wr(REG_IRQ_ENABLE, 32'h0);
		chk(32'(irq), 32'h0);
		wr(REG_IRQ_ENABLE, 32'h3f);
		wr(REG_IRQ_CLEAR, 32'h3f);
		chk(32'(irq), 32'h0);
		rchk(REG_IRQ_STATUS, 32'h3f, 32'h0);
		$display("test handshake done");
		phase <= 2'h2;
		req_code <= 3'h5;
		wait_cyc(30);
		chk(32'(feedback_current_output), 32'h0);
		wait_cyc(40);
		chk(32'(feedback_current_output), 32'h28);
		set_req(3'h1, 8'sh28);
		rchk(REG_IRQ_STATUS, 32'h6, 32'h6);
		meas_current_ma <= 13'h9c4;
		wait_cyc(20);
		chk(32'(feedback_current_output < 8'sh28), 32'h1);
		meas_current_ma <= 13'h3e8;
		wait_cyc(60);
		set_req(3'h0, 8'sh00);
		meas_current_ma <= 13'hdac;
		wait_cyc(40);
		chk(32'(feedback_current_output[7]), 32'h1);
		meas_current_ma <= 13'h3e8;
		wait_cyc(100);
		set_req(3'h3, 8'sh00);
		req_code <= 3'h7;
		wait_cyc(12);
		req_code <= 3'h3;
		wait_cyc(30);
		chk(32'(feedback_current_output), 32'h2);
		req_code <= 3'h1;
		wait_cyc(12);
		req_code <= 3'h3;
		wait_cyc(30);
		chk(32'(feedback_current_output), 32'h0);
		$display("test requests done");
		phase <= 2'h0;
		wait_cyc(40);
		chk(32'(fast_charge_indicator), 32'h0);
		chk(32'(dcp_short_en), 32'h1);
		chk(32'(feedback_current_output), 32'h0);
		rchk(REG_IRQ_STATUS, 32'h8, 32'h8);
		$display("test detach done");
		probe_low_cmp <= 1'b0;
		sel_strap_low <= 1'b1;
		sys_rst <= 1'b1;
		wait_cyc(20);
		sys_rst <= 1'b0;
		wait_cyc(30);
		rchk(REG_STATUS, 32'hc, 32'h8);
		for (int i = 0; i < 3; i++)
		begin
			ntc_above_vl <= ntc_tab[i][3];
			ntc_above_vh <= ntc_tab[i][2];
			ntc_above_sc <= ntc_tab[i][1];
			wait_cyc(10);
			chk(32'(temp_fault_flag), 32'(ntc_tab[i][0]));
		end
		attach();
		phase <= 2'h2;
		set_req(3'h1, 8'sh46);
		set_req(3'h3, 8'sh46);
		meas_current_ma <= 13'hdac;
		wait_cyc(40);
		chk(32'(feedback_current_output), 32'h46);
		wr(REG_CTRL, 32'h4);
		chk(32'(fast_charge_indicator), 32'h0);
		chk(32'(feedback_current_output), 32'h0);
		$display("test thermistor done");
		stop_test();
	end
endmodule : tb_usb_fast_charge_negotiator
`default_nettype wire
